// >>> rtl/gpcmd_handler.sv
/*
 Device-side handler of the general bus commands: remote/local and lockout,
 talker and listener addressing, interface clear, device clears, trigger
 gating and serial poll of the status byte.
 Assumes an external handshake engine presents each received byte as a
 one-cycle strobe with the ATN level sampled at the same time; the bus pins
 REN and IFC arrive asynchronously and are synchronised here.
*/
// Functional notes
// RULE1: REN alone never enters remote; need listen
// RULE2: Talking allowed in remote or local
// RULE3: Remote blocks panel keys except local
// RULE4: IFC forces local, idle, lamps off
// RULE5: IFC touches only interface addressing state; code also clears remote and serial poll enable
// RULE6: Controller holds IFC at least 100 us
// RULE7: LLO disables local key
// RULE8: Addressed GTL returns local, clears lockout
// RULE9: DCL acts without addressing
// RULE10: Clear empties buffers, cancels, aborts
// RULE11: Clear keeps configuration and data
// RULE12: SDC clears only when addressed listener
// RULE13: GET triggers only if bus source
// RULE14: GET honoured only when listener
// RULE15: Serial poll returns status byte anytime
// RULE16: Primary address defaults to seven
// RULE17: Responses sent only when addressed talker
// RULE18: UNL drops listener, UNT drops talker
// RULE19: Accept addresses zero through thirty
// RULE20: Listen addressing drops talker active
// RULE21: Commands decoded only under ATN
module gpcmd_handler
	import gpcmd_pkg::*;
(
	input  wire logic       core_clk,        // Core clock, 100 MHz
	input  wire logic       rst,             // Synchronous reset, active high
	input  wire logic       ren_pin,         // Remote enable line, asserted high
	input  wire logic       ifc_pin,         // Interface clear line, asserted high
	input  wire logic       rx_stb,          // Received byte strobe
	input  wire logic [7:0] rx_byte,         // Received byte
	input  wire logic       rx_atn,          // ATN level for rx_byte
	input  wire logic       addr_wr,         // Load new primary address
	input  wire logic [4:0] addr_in,         // New primary address
	input  wire logic       bus_trig_sel,    // Trigger source is the bus
	input  wire logic [7:0] status_byte,     // Status byte for serial poll
	input  wire logic       resp_valid,      // Response byte pending
	input  wire logic [7:0] resp_byte,       // Response byte
	input  wire logic       tx_ready,        // Handshake engine takes tx byte
	input  wire logic [7:0] panel_keys_in,   // Raw front panel keys
	input  wire logic       local_key,       // Local key press pulse
	output logic [4:0]      my_addr,         // Active primary address
	output logic            remote_lamp,     // Remote state indicator
	output logic            talk_lamp,       // Talker active indicator
	output logic            listener_lamp,   // Listener active indicator
	output logic            lockout,         // Local lockout in force
	output logic [7:0]      panel_keys_out,  // Front panel keys passed on
	output logic            data_stb,        // Device data byte pulse
	output logic [7:0]      data_byte,       // Device data byte
	output logic            dev_clear,       // Device clear pulse
	output logic            trig_pulse,      // Internal trigger pulse
	output logic            tx_valid,        // Byte offered for sending
	output logic [7:0]      tx_byte,         // Byte to send
	output logic            resp_take,       // Response byte consumed
	output logic            spoll_mode       // Serial poll mode active
);
	typedef enum logic [2:0] {
		GPCMD_T_IDLE = 3'b001,
		GPCMD_T_ACT  = 3'b010,
		GPCMD_T_SPAS = 3'b100
	} gpcmd_tstate_e;

	logic          ren_s;
	logic          ifc_s;
	logic [4:0]    addr_q;
	logic          lsn_q;
	gpcmd_tstate_e tst_q;
	logic          rem_q;
	logic          llo_q;
	logic          spe_q;
	logic          cmd_v;
	logic [6:0]    cmd;
	logic          is_mla;
	logic          is_mta;
	logic          is_ota;
	logic          lsn_d;

	////////////////////////////////////////////////////////////////////////
	gpcmd_sync #(.W(2)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        ({ren_pin, ifc_pin}),
		.q        ({ren_s, ifc_s})
	);

	// RULE21: ATN gates decode
	assign cmd_v  = rx_stb && rx_atn;
	assign cmd    = rx_byte[6:0];
	assign is_mla = cmd_v && cmd[6:5] == GPCMD_GRP_LSN && cmd[4:0] == addr_q;
	assign is_mta = cmd_v && cmd[6:5] == GPCMD_GRP_TLK && cmd[4:0] == addr_q;
	assign is_ota = cmd_v && cmd[6:5] == GPCMD_GRP_TLK && cmd[4:0] != addr_q
		&& cmd != GPCMD_CMD_UNT;

	////////////////////////////////////////////////////////////////////////
	// Primary address
	always_ff @(posedge core_clk) begin
		if (rst) begin
			// RULE16: factory address
			addr_q <= GPCMD_ADDR_RST;
		// RULE19: range zero to thirty
		end else if (addr_wr && addr_in <= GPCMD_ADDR_MAX) begin
			addr_q <= addr_in;
		end
	end
	assign my_addr = addr_q;

	////////////////////////////////////////////////////////////////////////
	// Listener state
	always_comb begin
		lsn_d = lsn_q;
		if (is_mla) begin
			lsn_d = 1'b1;
		// RULE18: unlisten
		end else if (cmd_v && cmd == GPCMD_CMD_UNL) begin
			lsn_d = 1'b0;
		end else if (is_mta) begin
			lsn_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		// RULE4: IFC idles listener
		if (rst || ifc_s) begin
			lsn_q <= 1'b0;
		end else begin
			lsn_q <= lsn_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Talker state; addressable in remote or local
	always_ff @(posedge core_clk) begin
		// RULE4: IFC idles talker
		if (rst || ifc_s) begin
			tst_q <= GPCMD_T_IDLE;
		end else begin
			case (tst_q)
				GPCMD_T_IDLE: begin
					// RULE2: talk regardless of remote
					if (is_mta) begin
						tst_q <= spe_q ? GPCMD_T_SPAS : GPCMD_T_ACT;
					end
				end
				GPCMD_T_ACT, GPCMD_T_SPAS: begin
					// RULE18: untalk drops talker
					if (cmd_v && (cmd == GPCMD_CMD_UNT || is_ota)) begin
						tst_q <= GPCMD_T_IDLE;
					// RULE20: listen address drops talker
					end else if (is_mla) begin
						tst_q <= GPCMD_T_IDLE;
					end else if (cmd_v && cmd == GPCMD_CMD_SPE) begin
						tst_q <= GPCMD_T_SPAS;
					end else if (cmd_v && cmd == GPCMD_CMD_SPD) begin
						tst_q <= GPCMD_T_ACT;
					end
				end
				default: tst_q <= GPCMD_T_IDLE;
			endcase
		end
	end

	// Serial poll enable latch, universal command
	always_ff @(posedge core_clk) begin
		if (rst || ifc_s) begin
			spe_q <= 1'b0;
		end else if (cmd_v && cmd == GPCMD_CMD_SPE) begin
			spe_q <= 1'b1;
		end else if (cmd_v && cmd == GPCMD_CMD_SPD) begin
			spe_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Remote and lockout
	always_ff @(posedge core_clk) begin
		// RULE4: IFC forces local
		if (rst || ifc_s || !ren_s) begin
			rem_q <= 1'b0;
		// RULE8: addressed go to local
		end else if (lsn_q && cmd_v && cmd == GPCMD_CMD_GTL) begin
			rem_q <= 1'b0;
		// RULE1: remote needs listen address
		end else if (is_mla) begin
			rem_q <= 1'b1;
		// RULE3: local key unless locked
		end else if (local_key && !llo_q) begin
			rem_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || !ren_s) begin
			llo_q <= 1'b0;
		// RULE8: GTL releases lockout
		end else if (lsn_q && cmd_v && cmd == GPCMD_CMD_GTL) begin
			llo_q <= 1'b0;
		// RULE7: lockout latch
		end else if (cmd_v && cmd == GPCMD_CMD_LLO) begin
			llo_q <= 1'b1;
		end
	end

	// RULE3: remote masks panel keys
	// RULE7: lockout masks panel keys
	assign panel_keys_out = (rem_q || llo_q) ? 8'h00 : panel_keys_in;

	////////////////////////////////////////////////////////////////////////
	// Event pulses; IFC does not touch settings or data
	// RULE5: no clear pulse from IFC
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dev_clear  <= 1'b0;
			trig_pulse <= 1'b0;
			data_stb   <= 1'b0;
			data_byte  <= 8'h00;
		end else begin
			// RULE9: DCL unaddressed
			// RULE12: SDC when listener
			// RULE10: clear pulse to queues
			// RULE11: clear leaves settings alone
			dev_clear  <= cmd_v && (cmd == GPCMD_CMD_DCL
				|| (cmd == GPCMD_CMD_SDC && lsn_q));
			// RULE13: bus trigger source only
			// RULE14: listener only
			trig_pulse <= cmd_v && cmd == GPCMD_CMD_GET && lsn_q && bus_trig_sel;
			// RULE21: data bytes when listening
			data_stb   <= rx_stb && !rx_atn && lsn_q;
			if (rx_stb && !rx_atn && lsn_q) begin
				data_byte <= rx_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Talk path
	// RULE15: poll answers status byte
	// RULE17: response only when talker
	assign tx_valid  = (tst_q == GPCMD_T_SPAS) || (tst_q == GPCMD_T_ACT && resp_valid);
	assign tx_byte   = (tst_q == GPCMD_T_SPAS) ? status_byte : resp_byte;
	assign resp_take = tst_q == GPCMD_T_ACT && resp_valid && tx_ready;

	// RULE4: lamps follow idle states
	assign remote_lamp   = rem_q;
	assign talk_lamp     = tst_q != GPCMD_T_IDLE;
	assign listener_lamp = lsn_q;
	assign lockout       = llo_q;
	assign spoll_mode    = tst_q == GPCMD_T_SPAS;

	////////////////////////////////////////////////////////////////////////
	a_ifc_idle: assert property (@(posedge core_clk) disable iff (rst)
		ifc_s |=> !lsn_q && tst_q == GPCMD_T_IDLE && !rem_q) // RULE4
		else $error("IFC did not idle interface");
	a_rem_needs_ren: assert property (@(posedge core_clk) disable iff (rst)
		$rose(rem_q) |-> $past(ren_s) && $past(is_mla)) // RULE1
		else $error("remote entered without listen address");
	a_llo_key: assert property (@(posedge core_clk) disable iff (rst)
		llo_q && rem_q && ren_s && !ifc_s && !lsn_q && local_key |=> rem_q) // RULE7
		else $error("local key worked under lockout");
	a_gtl_local: assert property (@(posedge core_clk) disable iff (rst)
		lsn_q && cmd_v && cmd == GPCMD_CMD_GTL |=> !rem_q && !llo_q) // RULE8
		else $error("GTL did not return local");
	a_dcl_clear: assert property (@(posedge core_clk) disable iff (rst)
		cmd_v && cmd == GPCMD_CMD_DCL |=> dev_clear) // RULE9
		else $error("DCL missed");
	a_sdc_addr: assert property (@(posedge core_clk) disable iff (rst)
		dev_clear |-> $past(cmd_v) && ($past(cmd) == GPCMD_CMD_DCL
			|| $past(lsn_q))) // RULE12
		else $error("SDC cleared unaddressed device");
	a_get_gate: assert property (@(posedge core_clk) disable iff (rst)
		trig_pulse |-> $past(lsn_q) && $past(bus_trig_sel)) // RULE13
		else $error("GET triggered without gating");
	a_get_lsn: assert property (@(posedge core_clk) disable iff (rst)
		cmd_v && cmd == GPCMD_CMD_GET && lsn_q && bus_trig_sel |=> trig_pulse) // RULE14
		else $error("GET not turned into trigger");
	a_poll_byte: assert property (@(posedge core_clk) disable iff (rst)
		spoll_mode |-> tx_valid && tx_byte == status_byte) // RULE15
		else $error("poll did not return status byte");
	a_tx_talker: assert property (@(posedge core_clk) disable iff (rst)
		tx_valid |-> talk_lamp) // RULE17
		else $error("sent while not talker");
	a_unl_drop: assert property (@(posedge core_clk) disable iff (rst)
		cmd_v && cmd == GPCMD_CMD_UNL && !ifc_s |=> !lsn_q) // RULE18
		else $error("UNL ignored");
	a_mla_untalk: assert property (@(posedge core_clk) disable iff (rst)
		is_mla && !ifc_s |=> tst_q == GPCMD_T_IDLE && lsn_q) // RULE20
		else $error("listen address kept talker");
	a_panel_mask: assert property (@(posedge core_clk) disable iff (rst)
		rem_q |-> panel_keys_out == 8'h00) // RULE3
		else $error("panel active in remote");
	a_data_noatn: assert property (@(posedge core_clk) disable iff (rst)
		data_stb |-> !$past(rx_atn)) // RULE21
		else $error("command taken as data");

	c_remote: cover property (@(posedge core_clk) disable iff (rst) $rose(rem_q));
	c_poll: cover property (@(posedge core_clk) disable iff (rst) spoll_mode && tx_ready);
	c_trig: cover property (@(posedge core_clk) disable iff (rst) trig_pulse);
	c_clear: cover property (@(posedge core_clk) disable iff (rst) dev_clear);
endmodule

// >>> rtl/gpcmd_pkg.sv
/*
 Constants for the bus command handler: command byte codes, address limits,
 reset values and the interface clear hold time.
 Assumes the bus is IEEE-488 with eight data lines and command bytes under ATN.
*/
package gpcmd_pkg;
	localparam logic [4:0] GPCMD_ADDR_RST   = 5'h07;
	localparam logic [4:0] GPCMD_ADDR_MAX   = 5'h1E;
	localparam logic [6:0] GPCMD_CMD_GTL    = 7'h01;
	localparam logic [6:0] GPCMD_CMD_SDC    = 7'h04;
	localparam logic [6:0] GPCMD_CMD_GET    = 7'h08;
	localparam logic [6:0] GPCMD_CMD_LLO    = 7'h11;
	localparam logic [6:0] GPCMD_CMD_DCL    = 7'h14;
	localparam logic [6:0] GPCMD_CMD_SPE    = 7'h18;
	localparam logic [6:0] GPCMD_CMD_SPD    = 7'h19;
	localparam logic [6:0] GPCMD_CMD_UNL    = 7'h3F;
	localparam logic [6:0] GPCMD_CMD_UNT    = 7'h5F;
	localparam logic [1:0] GPCMD_GRP_LSN    = 2'h1;
	localparam logic [1:0] GPCMD_GRP_TLK    = 2'h2;
	localparam int         GPCMD_CLK_MHZ    = 100;
	localparam int         GPCMD_IFC_US     = 100;
	localparam int         GPCMD_IFC_CYC    = GPCMD_IFC_US * GPCMD_CLK_MHZ;
endpackage

// >>> rtl/gpcmd_sync.sv
/*
 Two flip-flop synchroniser for a group of bus pins.
 Assumes the pins are asynchronous to core_clk.
*/
module gpcmd_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk, // Core clock
	input  wire logic         rst,      // Synchronous reset
	input  wire logic [W-1:0] d,        // Asynchronous inputs
	output logic      [W-1:0] q         // Synchronised outputs
);
	logic [W-1:0] meta_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// >>> tb/gpcmd_ctrl_model.sv
/*
 Bus controller model: sends command and data bytes, drives REN and IFC.
 Assumes the bench clock; every change is made on the falling edge.
*/
module gpcmd_ctrl_model
	import gpcmd_pkg::*;
(
	input  wire logic core_clk, // Core clock
	output logic       ren_pin,  // Remote enable
	output logic       ifc_pin,  // Interface clear
	output logic       rx_stb,   // Byte strobe
	output logic [7:0] rx_byte,  // Byte on the bus
	output logic       rx_atn    // Attention level
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ren_pin = 1'b0;
		ifc_pin = 1'b0;
		rx_stb = 1'b0;
		rx_byte = 8'h00;
		rx_atn = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// bus bytes, REN and IFC
	// Released lines show the inverse, never a stale value
	task automatic send(input logic atn, input logic [7:0] b);
		@(negedge core_clk);
		rx_stb = 1'b1;
		rx_atn = atn;
		rx_byte = b;
		@(negedge core_clk);
		rx_stb = 1'b0;
		rx_atn = ~atn;
		rx_byte = ~b;
	endtask
	task automatic set_ren(input logic v);
		@(negedge core_clk);
		ren_pin = v;
	endtask
	task automatic clear_bus();
		@(negedge core_clk);
		ifc_pin = 1'b1;
		repeat (GPCMD_IFC_CYC) @(negedge core_clk);
		ifc_pin = 1'b0;
	endtask
endmodule

// >>> tb/test_gpib_general_command_handler.sv
/*
 Self-checking bench for the bus command handler.
 Assumes the controller model drives the bus side and the bench the rest.
*/
module test_gpib_general_command_handler
	import gpcmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk = 1'b0, rst = 1'b1, addr_wr = 1'b0, bus_trig_sel = 1'b0;
	logic       resp_valid = 1'b0, tx_ready = 1'b0, local_key = 1'b0;
	logic       ren_pin, ifc_pin, rx_stb, rx_atn;
	logic [7:0] rx_byte, status_byte = 8'hA5, resp_byte = 8'h3C, panel_keys_in = 8'h5A;
	logic [4:0] addr_in = 5'h00, my_addr;
	logic       remote_lamp, talk_lamp, listener_lamp, lockout, data_stb;
	logic       dev_clear, trig_pulse, tx_valid, resp_take, spoll_mode;
	logic [7:0] panel_keys_out, data_byte, tx_byte;
	int         num_errors = 0, check_count = 0, cyc = 0, n_clr = 0, n_trg = 0, n_dat = 0;

	always #5 core_clk = ~core_clk;
	gpcmd_handler uut (
		.core_clk       (core_clk),
		.rst            (rst),
		.ren_pin        (ren_pin),
		.ifc_pin        (ifc_pin),
		.rx_stb         (rx_stb),
		.rx_byte        (rx_byte),
		.rx_atn         (rx_atn),
		.addr_wr        (addr_wr),
		.addr_in        (addr_in),
		.bus_trig_sel   (bus_trig_sel),
		.status_byte    (status_byte),
		.resp_valid     (resp_valid),
		.resp_byte      (resp_byte),
		.tx_ready       (tx_ready),
		.panel_keys_in  (panel_keys_in),
		.local_key      (local_key),
		.my_addr        (my_addr),
		.remote_lamp    (remote_lamp),
		.talk_lamp      (talk_lamp),
		.listener_lamp  (listener_lamp),
		.lockout        (lockout),
		.panel_keys_out (panel_keys_out),
		.data_stb       (data_stb),
		.data_byte      (data_byte),
		.dev_clear      (dev_clear),
		.trig_pulse     (trig_pulse),
		.tx_valid       (tx_valid),
		.tx_byte        (tx_byte),
		.resp_take      (resp_take),
		.spoll_mode     (spoll_mode)
	);
	gpcmd_ctrl_model ctl (.core_clk(core_clk), .ren_pin(ren_pin), .ifc_pin(ifc_pin),
		.rx_stb(rx_stb), .rx_byte(rx_byte), .rx_atn(rx_atn));
	////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		n_clr <= n_clr + int'(dev_clear === 1'b1);
		n_trg <= n_trg + int'(trig_pulse === 1'b1);
		n_dat <= n_dat + int'(data_stb === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (num_errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic cmd(input logic [7:0] b);
		ctl.send(1'b1, b);
	endtask
	// Counts pulses seen over the next three cycles
	task automatic pulses(input int c, input int t, input int d);
		int c0, t0, d0;
		c0 = n_clr;
		t0 = n_trg;
		d0 = n_dat;
		tick(3);
		chk(8'(n_clr - c0), 8'(c));
		chk(8'(n_trg - t0), 8'(t));
		chk(8'(n_dat - d0), 8'(d));
	endtask
	task automatic press_local();
		local_key = 1'b1;
		tick(1);
		local_key = 1'b0;
		tick(1);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_remote();
		chk(my_addr, 8'h07);
		ctl.set_ren(1'b1);
		tick(4);
		chk(remote_lamp, 1'b0);
		cmd(8'h27);
		chk(remote_lamp, 1'b1);
		chk(panel_keys_out, 8'h00);
		ctl.send(1'b0, 8'h14);
		pulses(0, 0, 1);
		chk(data_byte, 8'h14);
		press_local();
		chk(remote_lamp, 1'b0);
		chk(panel_keys_out, 8'h5A);
	endtask
	task automatic t_lockout();
		cmd(8'h27);
		cmd(8'h11);
		chk(lockout, 1'b1);
		cmd(8'h3F);
		chk(listener_lamp, 1'b0);
		press_local();
		chk(remote_lamp, 1'b1);
		cmd(8'h27);
		cmd(8'h01);
		chk(remote_lamp, 1'b0);
		chk(lockout, 1'b0);
	endtask
	task automatic t_clear();
		cmd(8'h3F);
		chk(listener_lamp, 1'b0);
		cmd(8'h04);
		pulses(0, 0, 0);
		cmd(8'h14);
		pulses(1, 0, 0);
		cmd(8'h27);
		cmd(8'h04);
		pulses(1, 0, 0);
		chk(my_addr, 8'h07);
		cmd(8'h08);
		pulses(0, 0, 0);
		bus_trig_sel = 1'b1;
		cmd(8'h08);
		pulses(0, 1, 0);
		cmd(8'h3F);
		cmd(8'h08);
		pulses(0, 0, 0);
	endtask
	task automatic t_talk();
		ctl.set_ren(1'b0);
		tick(4);
		resp_valid = 1'b1;
		tx_ready = 1'b1;
		#1;
		chk(tx_valid, 1'b0);
		cmd(8'h47);
		#1;
		chk(talk_lamp, 1'b1);
		chk(tx_byte, 8'h3C);
		chk(resp_take, 1'b1);
		resp_valid = 1'b0;
		tx_ready = 1'b0;
		cmd(8'h27);
		chk(talk_lamp, 1'b0);
		cmd(8'h18);
		cmd(8'h47);
		#1;
		chk(spoll_mode, 1'b1);
		chk(tx_byte, 8'hA5);
		cmd(8'h19);
		chk(spoll_mode, 1'b0);
		cmd(8'h5F);
		chk(talk_lamp, 1'b0);
		cmd(8'h47);
		chk(talk_lamp, 1'b1);
		cmd(8'h45);
		chk(talk_lamp, 1'b0);
	endtask
	task automatic t_addr_ifc();
		addr_in = 5'h1E;
		addr_wr = 1'b1;
		tick(1);
		addr_in = 5'h1F;
		tick(1);
		addr_wr = 1'b0;
		chk(my_addr, 8'h1E);
		ctl.set_ren(1'b1);
		tick(4);
		cmd(8'h3E);
		chk(remote_lamp, 1'b1);
		ctl.clear_bus();
		tick(4);
		chk(remote_lamp, 1'b0);
		chk(listener_lamp, 1'b0);
		chk(my_addr, 8'h1E);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		tick(12);
		rst = 1'b0;
		tick(3);
		t_remote();
		t_lockout();
		t_clear();
		t_talk();
		t_addr_ifc();
		give_verdict();
	end
endmodule
